// >>> include/card_defs.svh
// Constants of the card block write and erase controller.
`ifndef CARD_DEFS_SVH
`define CARD_DEFS_SVH
`define CMD_SELECT 6'h07
`define CMD_STOP 6'h0c
`define CMD_STATUS 6'h0d
`define CMD_BLKLEN 6'h10
`define CMD_WR_ONE 6'h18
`define CMD_WR_MULTI 6'h19
`define CMD_WR_CSD 6'h1b
`define CMD_ERASE_FIRST 6'h20
`define CMD_ERASE_LAST 6'h21
`define CMD_ERASE 6'h26
`define ACMD_WR_COUNT 6'h16
`define BLK_BYTES 12'h200
`define BLK_BYTES32 32'h0000_0200
`define CSD_BYTES 12'h010
`define LEN_MAX 12'hfff
`define CSD_RO_LSB 48
`define CSD_RESET 128'h0
`define ST_ADDR 30
`define ST_LEN 29
`define ST_ESEQ 28
`define ST_WP 26
`define ST_CSD 16
`define ST_SKIP 15
`define ST_ERST 13
`define ST_READY 8
`define FLAG_MASK 32'h7401_a000
`define REG_CFG 4'h0
`define REG_STAT 4'h1
`define REG_WPF 4'h2
`define REG_WPL 4'h3
`define REG_CNT 4'h4
`define CFG_PARTIAL 0
`define CFG_MISALIGN 1
`define CFG_ERASE_ONE 2
`define CFG_BLKSZ 5:4
`define TOK_OK 3'h2
`define TOK_CRC 3'h5
`define TOK_LAST 3'h5
`define CRC_POLY 16'h1021
`define CRC_LAST 4'hf
`define BYTE_LAST 4'h7
`endif

// >>> include/card_pkg.sv
// Types of the card block write and erase controller.
package card_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h2, S_CRC = 3'h3,
    S_END = 3'h4, S_TOKEN = 3'h5, S_BUSY = 3'h6, S_DRAIN = 3'h7
  } rx_state_t;
  typedef struct packed {
    logic valid;
    logic app;
    logic [5:0] idx;
    logic [31:0] arg;
  } cmd_t;
  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } rsp_t;
endpackage : card_pkg

// >>> verilog/card_block_write_erase.sv
// Card side block write, erase sequencing and write protection.
// Operation
// - Check block CRC before programming it.
// - Unaligned start address gives address fault.
// - Length not 512 gives length fault.
// - Short set-length accepted, checked at write.
// - Partial mode accepts short byte-granular blocks.
// - Bad CRC: report, discard, ignore later blocks.
// - Misaligned partial block stops programming first.
// - Misalign: address fault, drain until stop.
// - Protected write aborted; protect fault set only for a protected start address.
// - CARD_SPECIFIC_DATA_REG read-only mismatch: error, no change.
// - Hold DAT0 low while buffer is full.
// - Status reply shows ready-for-data anytime.
// - Deselect releases data line, programming continues.
// - Reselect pulls DAT0 low if still busy.
// - Report count of well written blocks.
// - Erase order first, last, erase else fault.
// - Other command except status resets erase sequence, flagged.
// - Protected sectors skipped in erase, flagged.
// - Erase addresses drop bits below block size.
// - Erase shows busy and allows deselect.
// - Erased value follows configuration bit 2.
// - Data CRC uses x16+x12+x5+1.
// - Blocks framed by low start, high end bit.
`timescale 1ns/1ps
`default_nettype none
`include "card_defs.svh"
module card_block_write_erase
  import card_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Card bus pins, sampled from outside the clock domain.
  input wire logic sd_clk_pin,
  input wire logic dat0_in,
  output logic dat0_out,
  output logic dat0_oe,
  // Decoded commands and their responses.
  input wire cmd_t cmd,
  input wire logic [15:0] card_rca,
  output rsp_t rsp,
  // Flash back end.
  output logic prog_req,
  output logic prog_erase,
  output logic [31:0] prog_addr,
  output logic [31:0] erase_last,
  output logic erase_fill,
  output logic [31:0] wp_first,
  output logic [31:0] wp_last,
  input wire logic prog_done,
  input wire logic [8:0] buf_rd_addr,
  output logic [7:0] buf_rd_data,
  output logic [127:0] csd_value,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata
);

  // One CRC step over one received bit.
  function automatic logic [15:0] crc16(input logic [15:0] c,
                                        input logic b);
    crc16 = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000);
  endfunction : crc16

  // True when a block of n bytes at a runs past a 512 byte boundary.
  function automatic logic crosses(input logic [31:0] a,
                                   input logic [11:0] n);
    crosses = ({3'h0, a[8:0]} + n) > `BLK_BYTES;
  endfunction : crosses

  // Drops the address bits below the block size.
  function automatic logic [31:0] align(input logic [31:0] a,
                                        input logic [1:0] sz);
    align = a & ~((`BLK_BYTES32 << sz) - 32'h0000_0001);
  endfunction : align

  logic clk_s1_r, clk_s2_r, clk_s3_r, dat_s1_r, dat_s2_r;
  logic [5:0] cfg_r;
  logic [31:0] wpf_r, wpl_r, flags_r, wcount_r, waddr_r;
  logic [31:0] efirst_r, elast_r, rd_mux, status_w;
  logic [31:0] cmd_set;
  logic [11:0] blklen_r, bytecnt_r, len_eff;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [15:0] crc_r;
  logic [5:0] txsr_r;
  logic [2:0] txcnt_r;
  logic [1:0] eseq_r;
  logic [127:0] csd_r, csd_rx_r;
  logic [7:0] wbuf [0:511];
  logic sel_r, multi_r, csd_mode_r, tok_ok_r, prog_req_r, prog_erase_r;
  logic ev_addr_r, ev_csd_r, ev_skip_r;
  rx_state_t st_r;
  rsp_t rsp_r;
  logic [31:0] reg_rdata_r;
  logic [7:0] buf_rd_data_r;

  // Two flip-flops on each pin before any logic looks at it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      {clk_s1_r, clk_s2_r, clk_s3_r} <= 3'h0;
      {dat_s1_r, dat_s2_r} <= 2'h3;
    end else if (ce) begin
      {clk_s1_r, clk_s2_r, clk_s3_r} <= {sd_clk_pin, clk_s1_r, clk_s2_r};
      {dat_s1_r, dat_s2_r} <= {dat0_in, dat_s1_r};
    end
  end

  // Bus clock edges and the decoded command classes.
  wire rise = ce & clk_s2_r & ~clk_s3_r;
  wire fall = ce & ~clk_s2_r & clk_s3_r;
  wire din = dat_s2_r;
  wire cmd_go = ce & cmd.valid;
  wire std = cmd_go & ~cmd.app;
  wire is_stop = std & (cmd.idx == `CMD_STOP);
  wire is_status = std & (cmd.idx == `CMD_STATUS);
  wire is_wr = std & ((cmd.idx == `CMD_WR_ONE) |
                      (cmd.idx == `CMD_WR_MULTI));
  wire is_csd = std & (cmd.idx == `CMD_WR_CSD);
  wire e_first = std & (cmd.idx == `CMD_ERASE_FIRST);
  wire e_lastc = std & (cmd.idx == `CMD_ERASE_LAST);
  wire e_go = std & (cmd.idx == `CMD_ERASE);
  wire e_cmd = e_first | e_lastc | e_go;
  wire is_count = cmd_go & cmd.app & (cmd.idx == `ACMD_WR_COUNT);
  wire partial = cfg_r[`CFG_PARTIAL];
  wire misal = cfg_r[`CFG_MISALIGN];
  wire idle = (st_r == S_IDLE) & sel_r;
  wire wp_on = wpf_r <= wpl_r;

  // Write command checks; the length is only judged here, never at set.
  wire len_bad = (blklen_r > `BLK_BYTES) | (blklen_r == 12'h000) |
                 (~partial & (blklen_r != `BLK_BYTES));
  wire addr_bad = ~partial & ~misal & (|cmd.arg[8:0]);
  wire cross_bad = partial & ~misal & crosses(cmd.arg, blklen_r);
  wire wp_hit = wp_on & (cmd.arg >= wpf_r) & (cmd.arg <= wpl_r);
  wire wr_ok = idle & is_wr & ~len_bad & ~addr_bad & ~cross_bad & ~wp_hit;
  wire csd_ok = idle & is_csd;
  wire [31:0] next_addr = waddr_r + {20'h0, blklen_r};
  wire next_bad = partial & ~misal & crosses(next_addr, blklen_r);
  wire next_wp = wp_on & (next_addr >= wpf_r) & (next_addr <= wpl_r);

  // Erase ordering; a status query leaves the sequence alone.
  wire eseq_bad = (e_first & (eseq_r != 2'h0)) |
                  (e_lastc & (eseq_r != 2'h1)) |
                  (e_go & (eseq_r != 2'h2));
  wire erst = cmd_go & (eseq_r != 2'h0) & ~e_cmd & ~is_status;
  wire erase_ok = idle & e_go & (eseq_r == 2'h2);
  wire skip = wp_on & (efirst_r <= wpl_r) & (elast_r >= wpf_r);

  // Flags raised by the command being answered now.
  always_comb begin
    cmd_set = 32'h0;
    cmd_set[`ST_ADDR] = idle & is_wr & (addr_bad | cross_bad);
    cmd_set[`ST_LEN] = idle & is_wr & len_bad;
    cmd_set[`ST_WP] = idle & is_wr & wp_hit;
    cmd_set[`ST_ESEQ] = sel_r & eseq_bad;
    cmd_set[`ST_ERST] = erst;
  end

  // The ready bit is live so a query during programming is truthful.
  assign status_w = ((flags_r | cmd_set) & `FLAG_MASK) |
                    ({31'h0, ~prog_req_r} << `ST_READY);

  // Sticky flags cleared by each response; data path events win.
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_r <= 32'h0;
    end else if (ce) begin
      flags_r <= ((flags_r | cmd_set) & ~(cmd_go ? `FLAG_MASK : 32'h0)) |
                 ({31'h0, ev_addr_r} << `ST_ADDR) |
                 ({31'h0, ev_csd_r} << `ST_CSD) |
                 ({31'h0, ev_skip_r} << `ST_SKIP);
    end
  end

  // Response word, one cycle after the command.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_r <= '0;
    end else if (ce) begin
      rsp_r.valid <= cmd_go;
      rsp_r.word <= is_count ? wcount_r : status_w;
    end
  end

  // Selection, block length and the erase sequence.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_r <= 1'b0;
      blklen_r <= `BLK_BYTES;
      eseq_r <= 2'h0;
      efirst_r <= 32'h0;
      elast_r <= 32'h0;
    end else if (ce) begin
      if (std & (cmd.idx == `CMD_SELECT))
        sel_r <= cmd.arg[31:16] == card_rca;
      if (idle & std & (cmd.idx == `CMD_BLKLEN))
        blklen_r <= (|cmd.arg[31:12]) ? `LEN_MAX : cmd.arg[11:0];
      if (sel_r & e_cmd & eseq_bad) begin
        eseq_r <= 2'h0;
      end else if (idle & e_first) begin
        eseq_r <= 2'h1;
        efirst_r <= align(cmd.arg, cfg_r[`CFG_BLKSZ]);
      end else if (idle & e_lastc) begin
        eseq_r <= 2'h2;
        elast_r <= align(cmd.arg, cfg_r[`CFG_BLKSZ]);
      end else if (erase_ok | erst) begin
        eseq_r <= 2'h0;
      end
    end
  end

  assign len_eff = csd_mode_r ? `CSD_BYTES : blklen_r;

  // Receive, token and busy sequencing on the sampled bus clock.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= S_IDLE;
      {multi_r, csd_mode_r, tok_ok_r, prog_req_r, prog_erase_r} <= 5'h0;
      {ev_addr_r, ev_csd_r, ev_skip_r} <= 3'h0;
      {bytecnt_r, bitcnt_r, shift_r, crc_r} <= 40'h0;
      {txsr_r, txcnt_r} <= 9'h1f8;
      waddr_r <= 32'h0;
      wcount_r <= 32'h0;
      csd_r <= `CSD_RESET;
      csd_rx_r <= 128'h0;
    end else if (ce) begin
      {ev_addr_r, ev_csd_r, ev_skip_r} <= 3'h0;
      unique case (st_r)
        S_IDLE: begin
          if (wr_ok | csd_ok) begin
            st_r <= S_START;
            waddr_r <= cmd.arg;
            multi_r <= wr_ok & (cmd.idx == `CMD_WR_MULTI);
            csd_mode_r <= csd_ok;
            if (wr_ok)
              wcount_r <= 32'h0;
          end else if (erase_ok) begin
            st_r <= S_BUSY;
            prog_req_r <= 1'b1;
            prog_erase_r <= 1'b1;
            ev_skip_r <= skip;
          end
        end
        S_START: begin
          if (is_stop) begin
            st_r <= S_IDLE;
          end else if (rise & ~din) begin
            st_r <= S_DATA;
            {bytecnt_r, bitcnt_r, crc_r} <= 32'h0;
          end
        end
        S_DATA: if (rise) begin
          shift_r <= {shift_r[6:0], din};
          csd_rx_r <= {csd_rx_r[126:0], din};
          crc_r <= crc16(crc_r, din);
          bitcnt_r <= bitcnt_r + 4'h1;
          if (bitcnt_r == `BYTE_LAST) begin
            bitcnt_r <= 4'h0;
            bytecnt_r <= bytecnt_r + 12'h001;
            if (bytecnt_r == len_eff - 12'h001)
              st_r <= S_CRC;
          end
        end
        S_CRC: if (rise) begin
          crc_r <= crc16(crc_r, din);
          bitcnt_r <= bitcnt_r + 4'h1;
          if (bitcnt_r == `CRC_LAST)
            st_r <= S_END;
        end
        S_END: if (rise) begin
          // A missing end bit counts as a failed transfer.
          tok_ok_r <= (crc_r == 16'h0000) & din;
          txsr_r <= {2'h2, ((crc_r == 16'h0000) & din) ? `TOK_OK :
                    `TOK_CRC, 1'b1};
          txcnt_r <= 3'h0;
          st_r <= S_TOKEN;
        end
        S_TOKEN: if (fall) begin
          txsr_r <= {txsr_r[4:0], 1'b1};
          txcnt_r <= txcnt_r + 3'h1;
          if (txcnt_r == `TOK_LAST) begin
            if (~tok_ok_r) begin
              st_r <= multi_r ? S_DRAIN : S_IDLE;
            end else if (csd_mode_r) begin
              st_r <= S_IDLE;
              if (csd_rx_r[127:`CSD_RO_LSB] == csd_r[127:`CSD_RO_LSB])
                csd_r <= csd_rx_r;
              else
                ev_csd_r <= 1'b1;
            end else begin
              st_r <= S_BUSY;
              prog_req_r <= 1'b1;
            end
          end
        end
        S_BUSY: begin
          if (is_stop)
            multi_r <= 1'b0;
          if (prog_done) begin
            prog_req_r <= 1'b0;
            prog_erase_r <= 1'b0;
            if (~prog_erase_r)
              wcount_r <= wcount_r + 32'h1;
            if (multi_r & ~is_stop & ~prog_erase_r) begin
              waddr_r <= next_addr;
              st_r <= (next_bad | next_wp) ? S_DRAIN : S_START;
              ev_addr_r <= next_bad;
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        S_DRAIN: if (is_stop) st_r <= S_IDLE;
      endcase
    end
  end

  // Write buffer; a failed block is overwritten by the next one.
  wire buf_we = rise & (st_r == S_DATA) & (bitcnt_r == `BYTE_LAST) &
                ~csd_mode_r;
  always_ff @(posedge mclk) begin
    if (ce & buf_we)
      wbuf[bytecnt_r[8:0]] <= {shift_r[6:0], din};
  end

  // Buffer read port for the flash back end.
  always_ff @(posedge mclk) begin
    if (rst)
      buf_rd_data_r <= 8'h00;
    else if (ce)
      buf_rd_data_r <= wbuf[buf_rd_addr];
  end

  // The line is driven only while selected, so a deselected card
  // keeps programming with the bus free for another card.
  assign dat0_oe = sel_r & ((st_r == S_TOKEN) |
                   ((st_r == S_BUSY) & prog_req_r));
  assign dat0_out = (st_r == S_TOKEN) & txsr_r[5];

  // Register file: configuration, protect window, status, count.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= 6'h00;
      wpf_r <= 32'hffff_ffff;
      wpl_r <= 32'h0;
    end else if (ce & reg_we) begin
      if (reg_addr == `REG_CFG)
        cfg_r <= reg_wdata[5:0];
      if (reg_addr == `REG_WPF)
        wpf_r <= reg_wdata;
      if (reg_addr == `REG_WPL)
        wpl_r <= reg_wdata;
    end
  end

  // Read selection; unmapped words read as zero.
  assign rd_mux = (reg_addr == `REG_CFG) ? {26'h0, cfg_r} :
                  (reg_addr == `REG_STAT) ? ((flags_r & `FLAG_MASK) |
                  ({31'h0, ~prog_req_r} << `ST_READY)) :
                  (reg_addr == `REG_WPF) ? wpf_r :
                  (reg_addr == `REG_WPL) ? wpl_r :
                  (reg_addr == `REG_CNT) ? wcount_r : 32'h0;
  always_ff @(posedge mclk) begin
    if (rst)
      reg_rdata_r <= 32'h0;
    else if (ce & reg_re)
      reg_rdata_r <= rd_mux;
  end

  // Output assignments.
  assign rsp = rsp_r;
  assign reg_rdata = reg_rdata_r;
  assign buf_rd_data = buf_rd_data_r;
  assign prog_req = prog_req_r;
  assign prog_erase = prog_erase_r;
  assign prog_addr = prog_erase_r ? efirst_r : waddr_r;
  assign erase_last = elast_r;
  assign erase_fill = cfg_r[`CFG_ERASE_ONE];
  assign wp_first = wpf_r;
  assign wp_last = wpl_r;
  assign csd_value = csd_r;

  // Checks on the block's own outputs and state.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_busy_drive: assert property (
    (st_r == S_BUSY) && prog_req_r && sel_r |-> dat0_oe && !dat0_out)
    else $error("busy not driven low");
  a_release_desel: assert property (
    !sel_r |-> !dat0_oe)
    else $error("deselected card drives data line");
  a_crc_first: assert property (
    $rose(prog_req_r) && !prog_erase_r |-> $past(tok_ok_r))
    else $error("programming without good crc");
  a_len_fault: assert property (
    cmd_go && idle && is_wr && !partial && blklen_r != `BLK_BYTES
    |=> rsp.valid && rsp.word[`ST_LEN] && st_r == S_IDLE)
    else $error("length fault missing");
  a_addr_fault: assert property (
    cmd_go && idle && is_wr && !partial && !misal && |cmd.arg[8:0]
    |=> rsp.word[`ST_ADDR] && st_r == S_IDLE)
    else $error("address fault missing");
  a_erase_order: assert property (
    sel_r && e_go && eseq_r != 2'h2 |=> rsp.word[`ST_ESEQ] &&
    eseq_r == 2'h0 && !prog_req_r)
    else $error("erase order fault missing");
  a_erase_reset: assert property (
    erst |=> rsp.word[`ST_ERST] && eseq_r == 2'h0)
    else $error("erase reset missing");
  a_release_done: assert property (
    ce && prog_done && (st_r == S_BUSY) |=> !prog_req_r ##1 !dat0_oe ||
    st_r == S_TOKEN)
    else $error("busy not released");
  a_drain_hold: assert property (
    (st_r == S_DRAIN) && !is_stop |=> st_r == S_DRAIN && !prog_req_r)
    else $error("drain left without stop");
  a_crc_discard: assert property (
    (st_r == S_TOKEN) && !tok_ok_r |-> !prog_req_r)
    else $error("failed block programmed");

  c_write_done: cover property ((st_r == S_BUSY) && prog_done && ce);
  c_crc_fail: cover property ((st_r == S_TOKEN) && !tok_ok_r);
  c_erase_run: cover property ($rose(prog_erase_r));
  c_desel_busy: cover property (!sel_r && prog_req_r);

endmodule : card_block_write_erase
`default_nettype wire

// >>> sim/host_model.sv
// Host side of the card bus: bus clock and write blocks on DAT0.
`timescale 1ns/1ps
`default_nettype none
`include "card_defs.svh"
module host_model (
  // Bus clock and host drive of DAT0.
  output logic sd_clk,
  output logic host_dat,
  output logic host_oe,
  // Resolved DAT0 level.
  input wire logic dat0
);
  logic [15:0] crc;

  // The bus clock stands low between frames; DAT0 is released to pull-up.
  // No socket switch is modelled, the tab is the host's own concern.
  initial begin
    sd_clk = 1'b0;
    host_dat = 1'b1;
    host_oe = 1'b0;
  end

  // One bit time: data changes while the clock is low.
  task automatic bit_out(input logic b);
    host_dat = b;
    #62.5 sd_clk = 1'b1;
    #62.5 sd_clk = 1'b0;
  endtask : bit_out

  // Sends n bytes of img, then clocks on to catch the card's token.
  task automatic send_block(input int n, input logic [127:0] img,
                            input logic bad, output logic [2:0] tok);
    logic [7:0] by;
    logic [11:0] seen;
    logic fb;
    logic found;
    crc = 16'h0;
    host_oe = 1'b1;
    bit_out(1'b0);
    for (int i = 0; i < n; i++) begin
      by = img[127 - 8 * (i % 16) -: 8];
      for (int k = 7; k >= 0; k--) begin
        fb = by[k] ^ crc[15];
        crc = {crc[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0);
        bit_out(by[k]);
      end
    end
    // A corrupted check word lets the bench provoke a refusal.
    if (bad) crc = ~crc;
    for (int k = 15; k >= 0; k--) bit_out(crc[k]);
    bit_out(1'b1);
    host_oe = 1'b0;
    seen = 12'hfff;
    for (int k = 0; k < 12; k++) begin
      #62.5 sd_clk = 1'b1;
      seen = {seen[10:0], dat0};
      #62.5 sd_clk = 1'b0;
    end
    // The token is the three bits after the first low bit seen.
    tok = 3'h7;
    found = 1'b0;
    for (int k = 11; k >= 3; k--) begin
      if (!found && seen[k] === 1'b0) begin
        tok = seen[k - 1 -: 3];
        found = 1'b1;
      end
    end
  endtask : send_block
endmodule : host_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench of the card block write and erase controller.
`timescale 1ns/1ps
`default_nettype none
`include "card_defs.svh"
module tb_top
  import card_pkg::*;
;
  localparam logic [127:0] IMG = 128'h3c5a_96e1_0f77_a5c3_1234_5678_9abc_def0;
  logic mclk, rst, ce, sd_clk, host_dat, host_oe, dat0, dat0_out, dat0_oe;
  logic prog_req, prog_erase, erase_fill, prog_done, reg_we, reg_re;
  logic [31:0] prog_addr, erase_last, reg_wdata, reg_rdata, w, v;
  logic [31:0] wp_first, wp_last;
  logic [3:0] reg_addr;
  logic [8:0] buf_rd_addr;
  logic [7:0] buf_rd_data;
  logic [127:0] csd_value;
  logic [2:0] tok;
  cmd_t cmd;
  rsp_t rsp;
  int n_fail, n_compared, i;
  logic [3:0] ra [5] = '{`REG_CFG, `REG_WPF, `REG_WPL, `REG_CNT, 4'hf};
  logic [31:0] rv [5] = '{32'h0, 32'hffff_ffff, 32'h0, 32'h0, 32'h0};

  // DAT0 has a pull-up, so a released line reads high.
  assign dat0 = dat0_oe ? dat0_out : (host_oe ? host_dat : 1'b1);

  card_block_write_erase i_card_block_write_erase (.mclk(mclk), .rst(rst),
    .ce(ce), .sd_clk_pin(sd_clk), .dat0_in(dat0), .dat0_out(dat0_out),
    .dat0_oe(dat0_oe), .cmd(cmd), .card_rca(16'h0001), .rsp(rsp),
    .prog_req(prog_req), .prog_erase(prog_erase), .prog_addr(prog_addr),
    .erase_last(erase_last), .erase_fill(erase_fill), .wp_first(wp_first),
    .wp_last(wp_last), .prog_done(prog_done), .buf_rd_addr(buf_rd_addr),
    .buf_rd_data(buf_rd_data), .csd_value(csd_value), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));
  host_model i_host_model (.sd_clk(sd_clk), .host_dat(host_dat),
    .host_oe(host_oe), .dat0(dat0));

  // Main clock, 4 ns period.
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : reg_wr

  // Read data stand from the cycle after the strobe until the next read.
  task automatic reg_rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_rd

  // A command is answered exactly one cycle after it is taken.
  task automatic cmd_go(input logic app, input logic [5:0] idx,
                        input logic [31:0] arg);
    @(posedge mclk);
    cmd <= '{1'b1, app, idx, arg};
    @(posedge mclk);
    cmd.valid <= 1'b0;
    #1;
    chk({31'h0, rsp.valid}, 32'h1);
    w = rsp.word;
  endtask : cmd_go

  // Flags may show in the command's own answer or the next status answer.
  task automatic cmd_flag(input logic [5:0] idx, input logic [31:0] arg,
                          input int b, input logic e);
    logic [31:0] x;
    cmd_go(1'b0, idx, arg);
    x = w;
    cmd_go(1'b0, `CMD_STATUS, 32'h0);
    x = x | w;
    chk({31'h0, x[b]}, {31'h0, e});
  endtask : cmd_flag

  task automatic done_pulse();
    @(posedge mclk);
    prog_done <= 1'b1;
    @(posedge mclk);
    prog_done <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : done_pulse

  task automatic wait_prog();
    for (int k = 0; k < 500 && prog_req !== 1'b1; k++) @(posedge mclk);
    #1;
  endtask : wait_prog

  task automatic endt(input string s);
    $display("Test %s finished at %0t", s, $time);
  endtask : endt

  task automatic tally_and_finish();
    $display("Compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // A hang is cut short well beyond the expected run of about 75 us.
  initial begin
    #300000;
    n_fail++;
    tally_and_finish();
  end

  // Test sequence.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cmd = '0;
    prog_done = 1'b0;
    buf_rd_addr = 9'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      reg_rd(ra[i]);
      chk(v, rv[i]);
    end
    chk({31'h0, dat0_oe}, 32'h0);
    endt("reset");
    cmd_go(1'b0, `CMD_SELECT, 32'h0001_0000);
    cmd_flag(`CMD_BLKLEN, 32'h4, `ST_LEN, 1'b0);
    cmd_flag(`CMD_WR_ONE, 32'h0, `ST_LEN, 1'b1);
    cmd_flag(`CMD_BLKLEN, `BLK_BYTES32, `ST_LEN, 1'b0);
    cmd_flag(`CMD_WR_ONE, 32'h10, `ST_ADDR, 1'b1);
    endt("faults");
    reg_wr(`REG_CFG, 32'h7);
    reg_rd(`REG_CFG);
    chk(v, 32'h7);
    cmd_flag(`CMD_BLKLEN, 32'h4, `ST_LEN, 1'b0);
    cmd_flag(`CMD_WR_ONE, 32'h400, `ST_LEN, 1'b0);
    i_host_model.send_block(4, IMG, 1'b0, tok);
    chk({29'h0, tok}, {29'h0, `TOK_OK});
    wait_prog();
    chk({30'h0, dat0_oe, dat0_out}, 32'h2);
    chk(prog_addr, 32'h400);
    @(posedge mclk);
    buf_rd_addr <= 9'h1;
    @(posedge mclk);
    #1;
    chk({24'h0, buf_rd_data}, {24'h0, IMG[119:112]});
    cmd_flag(`CMD_STATUS, 32'h0, `ST_READY, 1'b0);
    cmd_go(1'b0, `CMD_SELECT, 32'h0002_0000);
    chk({30'h0, dat0_oe, prog_req}, 32'h1);
    cmd_go(1'b0, `CMD_SELECT, 32'h0001_0000);
    chk({30'h0, dat0_oe, dat0_out}, 32'h2);
    done_pulse();
    chk({31'h0, dat0_oe}, 32'h0);
    cmd_flag(`CMD_STATUS, 32'h0, `ST_READY, 1'b1);
    cmd_go(1'b1, `ACMD_WR_COUNT, 32'h0);
    chk(w, 32'h1);
    endt("write");
    cmd_go(1'b0, `CMD_WR_ONE, 32'h600);
    i_host_model.send_block(4, IMG, 1'b1, tok);
    chk({29'h0, tok}, {29'h0, `TOK_CRC});
    repeat (20) @(posedge mclk);
    chk({31'h0, prog_req}, 32'h0);
    cmd_go(1'b0, `CMD_WR_MULTI, 32'h800);
    i_host_model.send_block(4, IMG, 1'b0, tok);
    wait_prog();
    done_pulse();
    for (i = 0; i < 2; i++) begin
      i_host_model.send_block(4, IMG, i == 0, tok);
      chk({29'h0, tok}, i == 0 ? {29'h0, `TOK_CRC} : 32'h7);
    end
    cmd_go(1'b0, `CMD_STOP, 32'h0);
    cmd_go(1'b1, `ACMD_WR_COUNT, 32'h0);
    chk(w, 32'h1);
    endt("crc");
    reg_wr(`REG_WPF, 32'h0);
    reg_wr(`REG_WPL, 32'h3ff);
    cmd_flag(`CMD_WR_ONE, 32'h200, `ST_WP, 1'b1);
    chk(wp_first, 32'h0);
    chk(wp_last, 32'h3ff);
    cmd_flag(`CMD_ERASE_LAST, 32'h0, `ST_ESEQ, 1'b1);
    cmd_flag(`CMD_ERASE, 32'h0, `ST_ESEQ, 1'b1);
    cmd_go(1'b0, `CMD_ERASE_FIRST, 32'h0);
    cmd_flag(`CMD_BLKLEN, 32'h4, `ST_ERST, 1'b1);
    cmd_go(1'b0, `CMD_ERASE_FIRST, 32'h3ff);
    cmd_flag(`CMD_ERASE_LAST, 32'h7ff, `ST_ESEQ, 1'b0);
    cmd_flag(`CMD_ERASE, 32'h0, `ST_SKIP, 1'b1);
    wait_prog();
    chk({28'h0, prog_erase, erase_fill, dat0_oe, dat0_out}, 32'he);
    chk(prog_addr, 32'h200);
    chk(erase_last, 32'h600);
    cmd_go(1'b0, `CMD_SELECT, 32'h0002_0000);
    chk({30'h0, dat0_oe, prog_req}, 32'h1);
    cmd_go(1'b0, `CMD_SELECT, 32'h0001_0000);
    done_pulse();
    reg_wr(`REG_WPF, 32'hffff_ffff);
    reg_wr(`REG_WPL, 32'h0);
    endt("erase");
    // Partial blocks without misalignment: the second block would cross.
    reg_wr(`REG_CFG, 32'h1);
    cmd_go(1'b0, `CMD_WR_MULTI, 32'h1fa);
    chk({31'h0, erase_fill}, 32'h0);
    i_host_model.send_block(4, IMG, 1'b0, tok);
    wait_prog();
    done_pulse();
    i_host_model.send_block(4, IMG, 1'b0, tok);
    chk({29'h0, tok}, 32'h7);
    cmd_flag(`CMD_STOP, 32'h0, `ST_ADDR, 1'b1);
    cmd_go(1'b1, `ACMD_WR_COUNT, 32'h0);
    chk(w, 32'h1);
    endt("misalign");
    // A read-only mismatch must leave the stored image as it was.
    cmd_go(1'b0, `CMD_WR_CSD, 32'h0);
    i_host_model.send_block(16, {128{1'b1}}, 1'b0, tok);
    repeat (40) @(posedge mclk);
    if (prog_req === 1'b1) done_pulse();
    cmd_flag(`CMD_STATUS, 32'h0, `ST_CSD, 1'b1);
    chk(csd_value[127:96] | csd_value[31:0], 32'h0);
    endt("csd");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
